// *** mbs_pkg.sv ***
// Constants, types and helpers shared by the serial query-handler design
// Contract
// - Answer only frames carrying our own address
// - Frame: address, function, data, CRC low first
// - Character: start, eight data, parity option, stops
// - CRC register starts all ones, XOR low
// - Eight right shifts, XOR A001 on carry
// - Recompute received CRC; mismatch marks frame bad
// - Bad frames get no response at all
// - Support register read 03 and write 10
// - Support relay read 01 and write 05
// - Read reply: byte count, words in order, CRC
// - Write reply echoes start and count, new CRC
// - Registers are sixteen bits, high byte first
// - Exception: address, function with MSB, code, CRC
// - Unsupported function returns code 81
// - Out-of-range register location returns code 82
// - Out-of-range written value returns code 83
// - Energy quantities span two consecutive registers
// - Zero pair to 000C/000D clears energy
// - Voltage register 0048 holds volts times 100
// - Never transmit unless answering an addressed query
// - Config high byte is address; zero is broadcast
// - Config low nibble selects baud 1200..9600
package mbs_pkg;

    localparam longint CLK_HZ         = 20_000_000;
    localparam longint CHAR_BITS      = 11;
    // Idle gap in tenths of a character time
    localparam longint GAP_TENTHS     = 35;
    localparam longint GAP_1200       = (GAP_TENTHS * CHAR_BITS * CLK_HZ + 12_000 - 1) / 12_000;
    localparam longint GAP_2400       = (GAP_TENTHS * CHAR_BITS * CLK_HZ + 24_000 - 1) / 24_000;
    localparam longint GAP_4800       = (GAP_TENTHS * CHAR_BITS * CLK_HZ + 48_000 - 1) / 48_000;
    localparam longint GAP_9600       = (GAP_TENTHS * CHAR_BITS * CLK_HZ + 96_000 - 1) / 96_000;
    localparam int     GAP_W          = 20;

    localparam int     BUF_BYTES      = 32;
    localparam int     MEAS_WORDS     = 10;
    localparam int     FIFO_DEPTH     = 16;

    localparam logic [15:0] CRC_INIT  = 16'hffff;
    localparam logic [15:0] CRC_POLY  = 16'ha001;

    localparam logic [7:0] FC_READ_COIL  = 8'h01;
    localparam logic [7:0] FC_READ_REGS  = 8'h03;
    localparam logic [7:0] FC_WRITE_COIL = 8'h05;
    localparam logic [7:0] FC_WRITE_REGS = 8'h10;
    localparam logic [7:0] EXC_FLAG      = 8'h80;
    localparam logic [7:0] ERR_FUNC      = 8'h81;
    localparam logic [7:0] ERR_ADDR      = 8'h82;
    localparam logic [7:0] ERR_VALUE     = 8'h83;
    localparam logic [7:0] BCAST_ADDR    = 8'h00;

    localparam logic [15:0] REG_MODEL1   = 16'h0000;
    localparam logic [15:0] REG_MODEL2   = 16'h0001;
    localparam logic [15:0] REG_VRANGE   = 16'h0002;
    localparam logic [15:0] REG_IRANGE   = 16'h0003;
    localparam logic [15:0] REG_CONFIG   = 16'h0004;
    localparam logic [15:0] REG_CLR_LO   = 16'h000c;
    localparam logic [15:0] REG_MEAS     = 16'h0048;
    localparam logic [15:0] REG_MEAS_END = 16'h0052;
    localparam logic [15:0] COIL_ADDR    = 16'h0000;
    localparam logic [15:0] COIL_ON      = 16'hff00;
    localparam logic [15:0] COIL_OFF     = 16'h0000;

    localparam logic [15:0] CONFIG_RST   = 16'h0105;
    localparam logic [3:0]  BAUD_1200    = 4'h3;
    localparam logic [3:0]  BAUD_2400    = 4'h4;
    localparam logic [3:0]  BAUD_4800    = 4'h5;
    localparam logic [3:0]  BAUD_9600    = 4'h6;

    localparam int     LEN_FIXED     = 8;
    localparam int     LEN_WR_HEAD   = 9;
    localparam int     LEN_EXC       = 3;
    localparam int     LEN_ECHO      = 6;
    localparam int     LEN_COIL      = 4;

    typedef enum logic [1:0] {
        ST_RECV  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_SEND  = 2'b10,
        ST_DRAIN = 2'b11
    } mbs_state_e;

    typedef enum logic [1:0] {
        RSP_EXC  = 2'b00,
        RSP_READ = 2'b01,
        RSP_ECHO = 2'b10,
        RSP_COIL = 2'b11
    } mbs_resp_e;

    // One byte through the reflected CRC16
    function automatic logic [15:0] mbs_crc_byte(input logic [15:0] crcIn,
                                                 input logic [7:0]  data);
        logic [15:0] c;
        c = crcIn ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

endpackage

// *** mbs_rtu_slave.sv ***
// Byte FIFO and the serial query handler that answers host frames
module mbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,       // System clock
    input  wire logic             rst_n,     // Async reset, active low
    input  wire logic             inValid,   // Write request
    output logic                  inReady,   // Space available
    input  wire logic [WIDTH-1:0] inData,    // Write data
    output logic                  outValid,  // Data available
    input  wire logic             outReady,  // Read request
    output logic      [WIDTH-1:0] outData    // Head of queue
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
    } mbs_fifo_s;

    mbs_fifo_s q;
    mbs_fifo_s next_q;
    logic      push;
    logic      pop;

    always_comb begin
        inReady  = (q.count != (AW+1)'(DEPTH));
        outValid = (q.count != '0);
        outData  = q.mem[q.rdPtr];
        push     = inValid && inReady;
        pop      = outValid && outReady;
        next_q   = q;
        if (push) begin
            next_q.mem[q.wrPtr] = inData;
            next_q.wrPtr        = (q.wrPtr == AW'(DEPTH - 1)) ? '0 : q.wrPtr + 1'b1;
        end
        if (pop) begin
            next_q.rdPtr = (q.rdPtr == AW'(DEPTH - 1)) ? '0 : q.rdPtr + 1'b1;
        end
        if (push && !pop) begin
            next_q.count = q.count + 1'b1;
        end else if (pop && !push) begin
            next_q.count = q.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule

module mbs_rtu_slave
    import mbs_pkg::*;
#(
    parameter int unsigned GAP_CYC_1200 = 32'(GAP_1200),
    parameter int unsigned GAP_CYC_2400 = 32'(GAP_2400),
    parameter int unsigned GAP_CYC_4800 = 32'(GAP_4800),
    parameter int unsigned GAP_CYC_9600 = 32'(GAP_9600),
    parameter logic [15:0] MODEL1_VAL   = 16'h0a01,  // Arbitrary identification value
    parameter logic [15:0] MODEL2_VAL   = 16'h0a02,  // Arbitrary identification value
    parameter logic [15:0] VRANGE_VAL   = 16'h00fa,
    parameter logic [15:0] IRANGE_VAL   = 16'h0032
) (
    input  wire logic                              clk,         // 20 MHz system clock
    input  wire logic                              rst_n,       // Async reset, active low
    input  wire logic [7:0]                        rxData,      // Received character
    input  wire logic                              rxValid,     // Character strobe
    input  wire logic                              rxError,     // Parity or framing fault
    input  wire logic [mbs_pkg::MEAS_WORDS*16-1:0] measWords,   // Measurement registers
    output logic      [7:0]                        txData,      // Character to send
    output logic                                   txValid,     // Character ready
    input  wire logic                              txReady,     // Transmitter takes char
    output logic                                   txBusy,      // Reply in progress
    output logic      [7:0]                        devAddr,     // Own bus address
    output logic      [1:0]                        cfgFormat,   // Parity and stop select
    output logic      [3:0]                        cfgBaud,     // Baud rate code
    output logic                                   relayOn,     // Relay output state
    output logic                                   energyClear  // One-cycle energy reset
);
    import mbs_pkg::*;

    typedef struct packed {
        mbs_state_e                  state;
        mbs_resp_e                   kind;
        logic [BUF_BYTES-1:0][7:0]   rxBuf;
        logic [5:0]                  rxCnt;
        logic                        rxBad;
        logic [GAP_W-1:0]            gapCnt;
        logic [15:0]                 crc;
        logic [15:0]                 crc1;
        logic [15:0]                 crc2;
        logic [7:0]                  lastByte;
        logic [7:0]                  prevByte;
        logic [7:0]                  excCode;
        logic [5:0]                  respLen;
        logic [5:0]                  txIdx;
        logic [15:0]                 txCrc;
        logic [7:0]                  devAddr;
        logic [1:0]                  cfgFormat;
        logic [3:0]                  cfgBaud;
        logic                        relayOn;
        logic                        energyClear;
        logic [7:0]                  txData;
        logic                        txValid;
        logic                        txBusy;
    } mbs_slave_s;

    mbs_slave_s r;
    mbs_slave_s next_r;

    logic             fifoInValid;
    logic             fifoInReady;
    logic [7:0]       fifoInData;
    logic             fifoOutValid;
    logic             fifoOutReady;
    logic [7:0]       fifoOutData;

    logic [7:0]       fc;
    logic [15:0]      start;
    logic [15:0]      cnt;
    logic [16:0]      endAddr;
    logic [15:0]      wrVal0;
    logic [15:0]      wrVal1;
    logic [GAP_W-1:0] gapLimit;
    logic [15:0]      rdAddr;
    logic [15:0]      rdWord;
    logic [5:0]       dataIdx;
    logic [7:0]       respByte;

    // Register read map; energy pairs are two adjacent measurement words
    function automatic logic [15:0] reg_word(input logic [15:0] a,
                                             input logic [MEAS_WORDS*16-1:0] m,
                                             input logic [7:0] addr,
                                             input logic [5:0] cfgLo);
        logic [15:0] off;
        off = a - REG_MEAS;
        unique case (a)
            REG_MODEL1: return MODEL1_VAL;
            REG_MODEL2: return MODEL2_VAL;
            REG_VRANGE: return VRANGE_VAL;
            REG_IRANGE: return IRANGE_VAL;
            REG_CONFIG: return {addr, cfgLo[5:4], 2'b00, cfgLo[3:0]};
            default:    return m[off[3:0]*16 +: 16];
        endcase
    endfunction

    always_comb begin
        fc      = r.rxBuf[1];
        start   = {r.rxBuf[2], r.rxBuf[3]};
        cnt     = {r.rxBuf[4], r.rxBuf[5]};
        endAddr = {1'b0, start} + {1'b0, cnt};
        wrVal0  = {r.rxBuf[7], r.rxBuf[8]};
        wrVal1  = {r.rxBuf[9], r.rxBuf[10]};
        unique case (r.cfgBaud)
            BAUD_1200: gapLimit = GAP_W'(GAP_CYC_1200);
            BAUD_2400: gapLimit = GAP_W'(GAP_CYC_2400);
            BAUD_9600: gapLimit = GAP_W'(GAP_CYC_9600);
            default:   gapLimit = GAP_W'(GAP_CYC_4800);
        endcase
        dataIdx = r.txIdx - 6'd3;
        rdAddr  = start + {11'd0, dataIdx[5:1]};
        rdWord  = reg_word(rdAddr, measWords, r.devAddr, {r.cfgFormat, r.cfgBaud});
        respByte = r.rxBuf[r.txIdx[4:0]];
        unique case (r.kind)
            RSP_EXC: begin
                if (r.txIdx == 6'd1) begin
                    respByte = fc | EXC_FLAG;
                end else if (r.txIdx == 6'd2) begin
                    respByte = r.excCode;
                end
            end
            RSP_READ: begin
                if (r.txIdx == 6'd2) begin
                    respByte = {1'b0, cnt[5:0], 1'b0};
                end else if (r.txIdx > 6'd2) begin
                    respByte = dataIdx[0] ? rdWord[7:0] : rdWord[15:8];
                end
            end
            RSP_COIL: begin
                if (r.txIdx == 6'd2) begin
                    respByte = 8'h01;
                end else if (r.txIdx == 6'd3) begin
                    respByte = {7'd0, r.relayOn};
                end
            end
            RSP_ECHO: begin
                respByte = r.rxBuf[r.txIdx[4:0]];
            end
        endcase
        fifoInValid = (r.state == ST_SEND);
        // CRC goes out low byte first
        if (r.txIdx < r.respLen) begin
            fifoInData = respByte;
        end else if (r.txIdx == r.respLen) begin
            fifoInData = r.txCrc[7:0];
        end else begin
            fifoInData = r.txCrc[15:8];
        end
        fifoOutReady = !r.txValid || txReady;
    end

    always_comb begin
        next_r             = r;
        next_r.energyClear = 1'b0;
        if (fifoOutReady) begin
            next_r.txValid = fifoOutValid;
            if (fifoOutValid) begin
                next_r.txData = fifoOutData;
            end
        end
        unique case (r.state)
            ST_RECV: begin
                if (rxValid) begin
                    if (r.rxCnt < 6'(BUF_BYTES)) begin
                        next_r.rxBuf[r.rxCnt[4:0]] = rxData;
                        next_r.rxCnt = r.rxCnt + 1'b1;
                    end else begin
                        next_r.rxBad = 1'b1;
                    end
                    if (rxError) begin
                        next_r.rxBad = 1'b1;
                    end
                    next_r.crc2     = r.crc1;
                    next_r.crc1     = r.crc;
                    next_r.crc      = mbs_crc_byte(r.crc, rxData);
                    next_r.prevByte = r.lastByte;
                    next_r.lastByte = rxData;
                    next_r.gapCnt   = '0;
                end else if (r.rxCnt != '0) begin
                    next_r.gapCnt = r.gapCnt + 1'b1;
                    if (r.gapCnt >= gapLimit) begin
                        next_r.state = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                next_r.state   = ST_RECV;
                next_r.txIdx   = '0;
                next_r.txCrc   = CRC_INIT;
                next_r.kind    = RSP_EXC;
                next_r.respLen = 6'(LEN_EXC);
                // Bad CRC, short frame or foreign address: stay silent
                if (r.rxCnt >= 6'd4 && !r.rxBad && (r.crc2 == {r.lastByte, r.prevByte})
                    && (r.rxBuf[0] == r.devAddr || r.rxBuf[0] == BCAST_ADDR)) begin
                    next_r.state = ST_SEND;
                    unique case (fc)
                        FC_READ_REGS: begin
                            if (r.rxCnt != 6'(LEN_FIXED)) begin
                                next_r.state = ST_RECV;
                            end else if (cnt != '0 && ((endAddr <= 17'({1'b0, REG_CONFIG} + 1'b1))
                                     || (start >= REG_MEAS && endAddr <= {1'b0, REG_MEAS_END}))) begin
                                next_r.kind    = RSP_READ;
                                next_r.respLen = 6'(LEN_EXC) + {cnt[4:0], 1'b0};
                            end else begin
                                next_r.excCode = ERR_ADDR;
                            end
                        end
                        FC_WRITE_REGS: begin
                            if (r.rxCnt != 6'(LEN_WR_HEAD) + r.rxBuf[6][5:0]) begin
                                next_r.state = ST_RECV;
                            end else if (start == REG_CONFIG && cnt == 16'd1) begin
                                if (r.rxBuf[6] == 8'd2 && wrVal0[15:8] != BCAST_ADDR
                                    && wrVal0[5:4] == 2'b00 && wrVal0[3:0] >= BAUD_1200
                                    && wrVal0[3:0] <= BAUD_9600) begin
                                    next_r.kind      = RSP_ECHO;
                                    next_r.respLen   = 6'(LEN_ECHO);
                                    next_r.devAddr   = wrVal0[15:8];
                                    next_r.cfgFormat = wrVal0[7:6];
                                    next_r.cfgBaud   = wrVal0[3:0];
                                end else begin
                                    next_r.excCode = ERR_VALUE;
                                end
                            end else if (start == REG_CLR_LO && cnt == 16'd2) begin
                                if (r.rxBuf[6] == 8'd4 && wrVal0 == '0 && wrVal1 == '0) begin
                                    next_r.kind        = RSP_ECHO;
                                    next_r.respLen     = 6'(LEN_ECHO);
                                    next_r.energyClear = 1'b1;
                                end else begin
                                    next_r.excCode = ERR_VALUE;
                                end
                            end else begin
                                next_r.excCode = ERR_ADDR;
                            end
                        end
                        FC_READ_COIL: begin
                            if (r.rxCnt != 6'(LEN_FIXED)) begin
                                next_r.state = ST_RECV;
                            end else if (start == COIL_ADDR && cnt == 16'd1) begin
                                next_r.kind    = RSP_COIL;
                                next_r.respLen = 6'(LEN_COIL);
                            end else begin
                                next_r.excCode = ERR_ADDR;
                            end
                        end
                        FC_WRITE_COIL: begin
                            if (r.rxCnt != 6'(LEN_FIXED)) begin
                                next_r.state = ST_RECV;
                            end else if (start != COIL_ADDR) begin
                                next_r.excCode = ERR_ADDR;
                            end else if (cnt == COIL_ON || cnt == COIL_OFF) begin
                                next_r.kind    = RSP_ECHO;
                                next_r.respLen = 6'(LEN_ECHO);
                                next_r.relayOn = (cnt == COIL_ON);
                            end else begin
                                next_r.excCode = ERR_VALUE;
                            end
                        end
                        default: begin
                            next_r.excCode = ERR_FUNC;
                        end
                    endcase
                    // Broadcast frames act but never answer
                    if (r.rxBuf[0] == BCAST_ADDR) begin
                        next_r.state = ST_RECV;
                    end
                end
                if (next_r.state == ST_SEND) begin
                    next_r.txBusy = 1'b1;
                end else begin
                    next_r.rxCnt = '0;
                    next_r.rxBad = 1'b0;
                    next_r.crc   = CRC_INIT;
                end
                next_r.gapCnt = '0;
            end
            ST_SEND: begin
                if (fifoInReady) begin
                    if (r.txIdx < r.respLen) begin
                        next_r.txCrc = mbs_crc_byte(r.txCrc, respByte);
                    end
                    next_r.txIdx = r.txIdx + 1'b1;
                    if (r.txIdx == r.respLen + 1'b1) begin
                        next_r.state = ST_DRAIN;
                    end
                end
            end
            ST_DRAIN: begin
                // Release the line once the last character has left
                if (!fifoOutValid && !r.txValid) begin
                    next_r.state  = ST_RECV;
                    next_r.txBusy = 1'b0;
                    next_r.rxCnt  = '0;
                    next_r.rxBad  = 1'b0;
                    next_r.crc    = CRC_INIT;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r           <= '0;
            r.state     <= ST_RECV;
            r.crc       <= CRC_INIT;
            r.txCrc     <= CRC_INIT;
            r.devAddr   <= CONFIG_RST[15:8];
            r.cfgFormat <= CONFIG_RST[7:6];
            r.cfgBaud   <= CONFIG_RST[3:0];
        end else begin
            r <= next_r;
        end
    end

    mbs_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_txFifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (fifoInData),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    assign txData      = r.txData;
    assign txValid     = r.txValid;
    assign txBusy      = r.txBusy;
    assign devAddr     = r.devAddr;
    assign cfgFormat   = r.cfgFormat;
    assign cfgBaud     = r.cfgBaud;
    assign relayOn     = r.relayOn;
    assign energyClear = r.energyClear;
endmodule

// *** mbs_rtu_slave_sva.sv ***
// Port-level timing checks for the serial query handler
module mbs_rtu_slave_sva #(
    parameter int unsigned GAP_CYC_4800 = 50
) (
    input wire logic       clk,         // Clock
    input wire logic       rst_n,       // Reset
    input wire logic       rxValid,     // Rx strobe
    input wire logic [7:0] txData,      // Tx char
    input wire logic       txValid,     // Tx valid
    input wire logic       txReady,     // Tx taken
    input wire logic       txBusy,      // Reply on
    input wire logic [7:0] devAddr,     // Address
    input wire logic [3:0] cfgBaud,     // Baud
    input wire logic       relayOn,     // Relay
    input wire logic       energyClear  // Clear
);
    logic [19:0] idleCnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Cycles since last rx strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) idleCnt <= '0;
        else if (rxValid) idleCnt <= '0;
        else if (idleCnt != '1) idleCnt <= idleCnt + 1'b1;
    end
    sequence s_decode; $rose(txBusy); endsequence
    sequence s_first; ##[1:8] txValid; endsequence
    chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("tx char changed");
    chk_tx_busy: assert property (txValid |-> txBusy)
        else $error("tx char outside a reply");
    chk_reply_start: assert property (s_decode |-> s_first)
        else $error("reply did not start");
    chk_gap_wait: assert property (s_decode |-> idleCnt >= GAP_CYC_4800)
        else $error("gap too short");
    chk_clear_pulse: assert property (energyClear |=> !energyClear)
        else $error("clear pulse too long");
    chk_busy_end: assert property ($fell(txBusy) |-> !txValid)
        else $error("busy fell early");
    chk_reset_vals: assert property ($rose(rst_n) |-> devAddr == 8'h01 && cfgBaud == 4'h5)
        else $error("bad reset config");
    chk_cfg_decode: assert property ($changed({devAddr, cfgBaud, relayOn}) || energyClear
        |-> idleCnt >= GAP_CYC_4800)
        else $error("early state change");
endmodule
bind mbs_rtu_slave mbs_rtu_slave_sva #(.GAP_CYC_4800(GAP_CYC_4800)) mbs_rtu_slave_sva_i (.*);

// *** mbs_host.sv ***
// Host model: sends queries, takes replies with stalls
module mbs_host (
    input  wire logic       clk,      // Clock
    output logic      [7:0] rxData,   // Char out
    output logic            rxValid,  // Strobe
    output logic            rxError,  // Fault
    input  wire logic [7:0] txData,   // Reply char
    input  wire logic       txValid,  // Reply valid
    output logic            txReady   // Reply taken
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    initial {rxData, rxValid, rxError, txReady} = '0;
    always @(posedge clk) begin
        if (txValid && txReady) got.push_back(txData);
        txReady <= ($urandom_range(3, 0) != 0);
    end
    function automatic void add_crc(ref logic [7:0] q[$]);
        logic [15:0] c = 16'hffff;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
    endfunction
    task automatic send(input logic [7:0] f[$], input logic [1:0] err);
        add_crc(f);
        if (err[0]) f[f.size() - 1] ^= 8'h01;
        foreach (f[i]) begin
            @(posedge clk);
            rxData <= f[i];
            rxValid <= 1'b1;
            rxError <= err[1];
            @(posedge clk);
            rxValid <= 1'b0;
            rxData <= ~f[i];
        end
    endtask
endmodule

// *** mbs_rtu_slave_bench.sv ***
// Self-checking bench for the serial query handler
module mbs_rtu_slave_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int GAP = 50;
    logic clk, rst_n, rxValid, rxError, txValid, txReady, txBusy, relayOn, energyClear;
    logic [7:0]   rxData, txData, devAddr;
    logic [1:0]   cfgFormat;
    logic [3:0]   cfgBaud;
    logic [159:0] measWords;
    logic [183:0] x;
    int           mismatches;
    int           n_compared;
    int           s, n, clears;
    mbs_rtu_slave #(.GAP_CYC_1200(GAP), .GAP_CYC_2400(GAP), .GAP_CYC_4800(GAP),
        .GAP_CYC_9600(GAP)) mbs_rtu_slave_i (.clk(clk), .rst_n(rst_n), .rxData(rxData),
        .rxValid(rxValid), .rxError(rxError), .measWords(measWords), .txData(txData),
        .txValid(txValid), .txReady(txReady), .txBusy(txBusy), .devAddr(devAddr),
        .cfgFormat(cfgFormat), .cfgBaud(cfgBaud), .relayOn(relayOn),
        .energyClear(energyClear));
    mbs_host mbs_host_i (.clk(clk), .rxData(rxData), .rxValid(rxValid),
        .rxError(rxError), .txData(txData), .txValid(txValid), .txReady(txReady));
    always @(negedge clk) clears += energyClear;
    task automatic bad(input string m);
        mismatches++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic check_b(input logic a, input logic e);
        n_compared++;
        if (a !== e) bad("output value");
    endtask
    // Packed bytes, first byte leftmost
    task automatic run(input logic [95:0] fv, input int fl, input logic [1:0] err,
                       input logic [183:0] xv, input int xl);
        logic [7:0] f[$], q[$];
        for (int i = fl - 1; i >= 0; i--) f.push_back(fv[8*i +: 8]);
        for (int i = xl - 1; i >= 0; i--) q.push_back(xv[8*i +: 8]);
        if (xl != 0) mbs_host_i.add_crc(q);
        mbs_host_i.send(f, err);
        repeat (GAP + 12) @(posedge clk);
        while (txBusy !== 1'b0) @(posedge clk);
        n_compared++;
        if (mbs_host_i.got.size() != q.size()) bad("reply length");
        else foreach (q[i]) if (mbs_host_i.got[i] !== q[i]) bad("reply byte");
        mbs_host_i.got.delete();
    endtask
    task automatic stop_test;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Over twenty times the run length
    initial begin
        repeat (40000) @(posedge clk);
        bad("timeout");
        stop_test();
    end
    initial begin
        rst_n = 1'b0;
        measWords = '0;
        void'($urandom(32'h3bd4));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int t = 0; t < 4; t++) begin
            s = $urandom_range(9, 0);
            n = $urandom_range(10 - s, 1);
            measWords <= {$urandom, $urandom, $urandom, $urandom, $urandom};
            @(posedge clk);
            x = {8'h01, 8'h03, 8'(2 * n)};
            for (int i = s; i < s + n; i++) x = (x << 16) | measWords[16*i +: 16];
            run({8'h01, 8'h03, 8'h00, 8'(8'h48 + s), 8'h00, 8'(n)}, 6, 0, x, 3 + 2 * n);
        end
        run(48'h010300000005, 6, 0, 104'h01030a0a010a0200fa00320105, 13);
        run(48'h020300480001, 6, 0, 0, 0);
        run(48'h010300480001, 6, 1, 0, 0);
        run(48'h010300480001, 6, 2, 0, 0);
        run(48'h010400480001, 6, 0, 24'h018481, 3);
        run(48'h010300510002, 6, 0, 24'h018382, 3);
        run(72'h011000480001020000, 9, 0, 24'h019082, 3);
        run(88'h0110000c00020400010000, 11, 0, 24'h019083, 3);
        run(88'h0110000c00020400000000, 11, 0, 48'h0110000c0002, 6);
        check_b(clears == 1, 1'b1);
        run(48'h00050000ff00, 6, 0, 0, 0);
        check_b(relayOn, 1'b1);
        run(48'h010100000001, 6, 0, 32'h01010101, 4);
        run(48'h010500001234, 6, 0, 24'h018583, 3);
        run(48'h010500000000, 6, 0, 48'h010500000000, 6);
        check_b(relayOn, 1'b0);
        run(72'h011000040001020207, 9, 0, 24'h019083, 3);
        run(72'h011000040001020246, 9, 0, 48'h011000040001, 6);
        check_b(devAddr === 8'h02 && cfgBaud === 4'h6, 1'b1);
        check_b(cfgFormat == 2'b01, 1'b1);
        run(48'h020300480001, 6, 0, {8'h02, 8'h03, 8'h02, measWords[15:0]}, 5);
        stop_test();
    end
endmodule
